// ==== common/cic_defs.vh ====
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH
`define CIC_ADDR_W 4
`define CIC_OFF_CTRL_S 4'h0
`define CIC_OFF_CTRL_NS 4'h1
`define CIC_OFF_EOI 4'h2
`define CIC_OFF_DIR 4'h3
`define CIC_OFF_BPR 4'h4
`define CIC_OFF_ABPR 4'h5
`define CIC_OFF_STATUS 4'h6
`define CIC_OFF_PEND 4'h7
`define CIC_B_G0EN 0
`define CIC_B_G1EN 1
`define CIC_B_GRP0_FAST_ROUTE 3
`define CIC_B_COMMON_BINARY_POINT 4
`define CIC_B_FBD0 5
`define CIC_B_IBD0 6
`define CIC_B_FBD1 7
`define CIC_B_IBD1 8
`define CIC_B_EOIS 9
`define CIC_B_EOINS 10
`define CIC_NS_G1EN 0
`define CIC_NS_FBD1 5
`define CIC_NS_IBD1 6
`define CIC_NS_EOINS 9
`define CIC_CTRL_RESET 32'h0000_0000
`define CIC_BPR_RESET 3'h2
`define CIC_ABPR_RESET 3'h3
`endif

// ==== hdl/cic_route.v ====
`timescale 1ns/1ps
module cic_route (
  input wire g0_pend,
  input wire g1_pend,
  input wire g0_en,
  input wire g1_en,
  input wire fast_route,
  input wire irq_byp,
  input wire fiq_byp,
  input wire ibd0,
  input wire fbd0,
  input wire ibd1,
  input wire fbd1,
  output wire irq_o,
  output wire fiq_o
);
  wire g0_act = g0_pend & g0_en;
  wire g1_act = g1_pend & g1_en;
  wire irq_sig = (g0_act & ~fast_route) | g1_act;
  wire fiq_sig = g0_act & fast_route;
  wire irq_off = ~(g0_en & ~fast_route) & ~g1_en;
  wire fiq_off = ~(g0_en & fast_route);
  // bypass passes only while the line's signalling is disabled
  assign irq_o = irq_sig | (irq_off & irq_byp & ~(ibd0 & ibd1));
  assign fiq_o = fiq_sig | (fiq_off & fiq_byp & ~(fbd0 & fbd1));
endmodule

// ==== hdl/cic_preempt.v ====
`timescale 1ns/1ps
module cic_preempt (
  input wire [2:0] bpr,
  input wire [2:0] abpr,
  input wire common_binary_point,
  input wire is_grp1,
  input wire [7:0] pend_prio,
  input wire [7:0] run_prio,
  output wire preempt
);
  function [7:0] grp_mask;
    input [2:0] bp;
    begin
      grp_mask = 8'hfe << bp;
    end
  endfunction
  wire [2:0] bp_sel = (is_grp1 & ~common_binary_point) ? abpr : bpr;
  wire [7:0] m = grp_mask(bp_sel);
  assign preempt = (pend_prio & m) < (run_prio & m);
endmodule

// ==== hdl/cic_ctrl.v ====
`timescale 1ns/1ps
`include "cic_defs.vh"
// Overview of operation
// - bit 10 aliases nonsecure split eoi mode
// - mode 0: eoi drops priority and deactivates
// - mode 1: eoi drops only; deactivate separate
// - secure bit governs secure accesses only
// - bit 8 aliases grp1 normal bypass disable
// - bit 7 aliases grp1 fast bypass disable
// - bit 6 with bit 8 blocks normal bypass when disabled
// - bit 5 with bit 7 blocks fast bypass when disabled
// - common_binary_point 0: group 1 uses aliased point
// - common_binary_point 1: main point for both groups
// - bit 3 routes group 0 fast/normal
// - group 1 always on normal line
// - earlier version: bits 10..5 reserved
// - fast route resets to zero
// - bits 31..11 reserved
// - bit 0 enables group 0 signalling
// - bit 1 enables group 1 signalling
module cic_ctrl #(
  parameter V2 = 1,
  parameter SECURE = 1
) (
  input wire CLOCK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire NS_ACCESS,
  output reg [31:0] RDATA,
  input wire G0_PEND,
  input wire G1_PEND,
  input wire [7:0] PEND_PRIO,
  input wire PEND_GRP1,
  input wire IRQ_BYPASS,
  input wire FIQ_BYPASS,
  output reg IRQ_OUT,
  output reg FIQ_OUT,
  output reg PREEMPT,
  output reg PRIO_DROP,
  output reg DEACT,
  output reg [9:0] DEACT_ID
);
  localparam V2B = (V2 != 0) ? 1'b1 : 1'b0;
  localparam SECB = ((V2 != 0) && (SECURE != 0)) ? 1'b1 : 1'b0;
  reg g0en_r, g1en_r, grp0_fast_route_r, common_binary_point_r, fbd0_r, ibd0_r, fbd1_r, ibd1_r, eois_r, eoins_r;
  reg [2:0] bpr_r, abpr_r;
  reg [7:0] run_prio_r;
  reg [7:0] saved_prio_r;
  wire wr_s = WR & (ADDR == `CIC_OFF_CTRL_S) & ~(SECB & NS_ACCESS);
  wire wr_ns = WR & (((ADDR == `CIC_OFF_CTRL_S) & SECB & NS_ACCESS) | ((ADDR == `CIC_OFF_CTRL_NS) & SECB));
  wire eoi_w = WR & (ADDR == `CIC_OFF_EOI);
  wire dir_w = WR & (ADDR == `CIC_OFF_DIR);
  wire split = (SECB & NS_ACCESS) ? eoins_r : eois_r;
  always @(posedge CLOCK) begin
    if (RST) begin
      g0en_r <= 1'b0;
      g1en_r <= 1'b0;
      grp0_fast_route_r <= 1'b0;
      common_binary_point_r <= 1'b0;
      fbd0_r <= 1'b0;
      ibd0_r <= 1'b0;
      fbd1_r <= 1'b0;
      ibd1_r <= 1'b0;
      eois_r <= 1'b0;
      eoins_r <= 1'b0;
      bpr_r <= `CIC_BPR_RESET;
      abpr_r <= `CIC_ABPR_RESET;
    end else begin
      if (wr_s) begin
        g0en_r <= WDATA[`CIC_B_G0EN];
        g1en_r <= WDATA[`CIC_B_G1EN];
        grp0_fast_route_r <= WDATA[`CIC_B_GRP0_FAST_ROUTE];
        common_binary_point_r <= WDATA[`CIC_B_COMMON_BINARY_POINT];
        fbd0_r <= WDATA[`CIC_B_FBD0] & V2B;
        ibd0_r <= WDATA[`CIC_B_IBD0] & V2B;
        fbd1_r <= WDATA[`CIC_B_FBD1] & V2B;
        ibd1_r <= WDATA[`CIC_B_IBD1] & V2B;
        eois_r <= WDATA[`CIC_B_EOIS] & V2B;
        eoins_r <= WDATA[`CIC_B_EOINS] & SECB;
      end else if (wr_ns) begin
        g1en_r <= WDATA[`CIC_NS_G1EN];
        fbd1_r <= WDATA[`CIC_NS_FBD1];
        ibd1_r <= WDATA[`CIC_NS_IBD1];
        eoins_r <= WDATA[`CIC_NS_EOINS];
      end
      if (WR & (ADDR == `CIC_OFF_BPR))
        bpr_r <= WDATA[2:0];
      if (WR & (ADDR == `CIC_OFF_ABPR))
        abpr_r <= WDATA[2:0];
    end
  end
  // single-level active priority tracking
  always @(posedge CLOCK) begin
    if (RST) begin
      run_prio_r <= 8'hff;
      saved_prio_r <= 8'hff;
      PRIO_DROP <= 1'b0;
      DEACT <= 1'b0;
      DEACT_ID <= 10'h000;
    end else begin
      PRIO_DROP <= eoi_w;
      DEACT <= (eoi_w & ~split) | (dir_w & split);
      if (eoi_w | dir_w)
        DEACT_ID <= WDATA[9:0];
      if (eoi_w)
        run_prio_r <= 8'hff;
      else if (WR & (ADDR == `CIC_OFF_PEND)) begin
        run_prio_r <= WDATA[7:0];
        saved_prio_r <= run_prio_r;
      end
    end
  end
  wire irq_c, fiq_c, pre_c;
  cic_route u_route (
    .g0_pend(G0_PEND),
    .g1_pend(G1_PEND),
    .g0_en(g0en_r),
    .g1_en(g1en_r),
    .fast_route(grp0_fast_route_r),
    .irq_byp(IRQ_BYPASS),
    .fiq_byp(FIQ_BYPASS),
    .ibd0(ibd0_r),
    .fbd0(fbd0_r),
    .ibd1(ibd1_r),
    .fbd1(fbd1_r),
    .irq_o(irq_c),
    .fiq_o(fiq_c)
  );
  cic_preempt u_pre (
    .bpr(bpr_r),
    .abpr(abpr_r),
    .common_binary_point(common_binary_point_r),
    .is_grp1(PEND_GRP1),
    .pend_prio(PEND_PRIO),
    .run_prio(run_prio_r),
    .preempt(pre_c)
  );
  always @(posedge CLOCK) begin
    if (RST) begin
      IRQ_OUT <= 1'b0;
      FIQ_OUT <= 1'b0;
      PREEMPT <= 1'b0;
    end else begin
      IRQ_OUT <= irq_c;
      FIQ_OUT <= fiq_c;
      PREEMPT <= pre_c;
    end
  end
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    if ((ADDR == `CIC_OFF_CTRL_S) & ~(SECB & NS_ACCESS)) begin
      rd_nxt[`CIC_B_G0EN] = g0en_r;
      rd_nxt[`CIC_B_G1EN] = g1en_r;
      rd_nxt[`CIC_B_GRP0_FAST_ROUTE] = grp0_fast_route_r;
      rd_nxt[`CIC_B_COMMON_BINARY_POINT] = common_binary_point_r;
      rd_nxt[`CIC_B_FBD0] = fbd0_r;
      rd_nxt[`CIC_B_IBD0] = ibd0_r;
      rd_nxt[`CIC_B_FBD1] = fbd1_r;
      rd_nxt[`CIC_B_IBD1] = ibd1_r;
      rd_nxt[`CIC_B_EOIS] = eois_r;
      rd_nxt[`CIC_B_EOINS] = eoins_r;
    end else if (((ADDR == `CIC_OFF_CTRL_S) | (ADDR == `CIC_OFF_CTRL_NS)) & SECB) begin
      rd_nxt[`CIC_NS_G1EN] = g1en_r;
      rd_nxt[`CIC_NS_FBD1] = fbd1_r;
      rd_nxt[`CIC_NS_IBD1] = ibd1_r;
      rd_nxt[`CIC_NS_EOINS] = eoins_r;
    end else if (ADDR == `CIC_OFF_BPR)
      rd_nxt[2:0] = bpr_r;
    else if (ADDR == `CIC_OFF_ABPR)
      rd_nxt[2:0] = abpr_r;
    else if (ADDR == `CIC_OFF_STATUS) begin
      rd_nxt[0] = IRQ_OUT;
      rd_nxt[1] = FIQ_OUT;
      rd_nxt[2] = PREEMPT;
    end else if (ADDR == `CIC_OFF_PEND) begin
      rd_nxt[7:0] = run_prio_r;
      rd_nxt[15:8] = saved_prio_r;
    end
  end
  always @(posedge CLOCK) begin
    if (RST)
      RDATA <= 32'h0000_0000;
    else if (RD)
      RDATA <= rd_nxt;
    else
      RDATA <= 32'h0000_0000;
  end
endmodule

// ==== test/cic_core_model.sv ====
`timescale 1ns/1ps
module cic_core_model (
  input wire clk,
  input wire rst,
  input wire irq,
  input wire fast_request_line,
  output reg irq_seen,
  output reg fiq_seen
);
  // core samples both request levels every cycle
  always @(posedge clk) begin
    irq_seen <= !rst && irq;
    fiq_seen <= !rst && fast_request_line;
  end
endmodule

// ==== test/cic_ctrl_props.sv ====
`timescale 1ns/1ps
module cic_chk (
  input wire CLOCK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire G0_PEND,
  input wire G1_PEND,
  input wire IRQ_BYPASS,
  input wire FIQ_BYPASS,
  input wire IRQ_OUT,
  input wire FIQ_OUT,
  input wire PRIO_DROP,
  input wire DEACT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_eoi_drop: assert property (WR && ADDR == 4'h2 |=> PRIO_DROP) else $error("no drop");
  chk_drop_cause: assert property (PRIO_DROP |-> $past(WR) && $past(ADDR) == 4'h2) else $error("bad drop");
  chk_deact_cause: assert property (DEACT |-> $past(WR) && ($past(ADDR) == 4'h2 || $past(ADDR) == 4'h3))
    else $error("bad deact");
  chk_idle_rdata: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("rdata not 0");
  chk_rsvd_zero: assert property ($past(RD) && $past(ADDR) < 4'h2 |-> RDATA[31:11] == 21'h0)
    else $error("reserved set");
  chk_unmapped_zero: assert property ($past(RD) && $past(ADDR) > 4'h7 |-> RDATA == 32'h0)
    else $error("unmapped read");
  chk_norm_idle: assert property (!$past(G0_PEND) && !$past(G1_PEND) && !$past(IRQ_BYPASS) |-> !IRQ_OUT)
    else $error("stray irq");
  chk_fast_grp1: assert property (!$past(G0_PEND) && !$past(FIQ_BYPASS) |-> !FIQ_OUT)
    else $error("stray fiq");
endmodule
bind cic_ctrl cic_chk chk (.*);

// ==== test/cpu_if_secure_control_bits_tb.sv ====
`timescale 1ns/1ps
module cpu_if_secure_control_bits_tb;
  reg CLOCK = 0, RST = 1, WR = 0, RD = 0, NS_ACCESS = 0;
  reg G0_PEND = 0, G1_PEND = 0, PEND_GRP1 = 0, IRQ_BYPASS = 0, FIQ_BYPASS = 0;
  reg [3:0] ADDR = 0;
  reg [31:0] WDATA = 0, s;
  reg [7:0] PEND_PRIO = 0;
  wire [31:0] RDATA;
  wire IRQ_OUT, FIQ_OUT, PREEMPT, PRIO_DROP, DEACT, irq_seen, fiq_seen;
  wire [9:0] DEACT_ID;
  integer failures = 0, total_checks = 0, cyc = 0, i;
  always #2 CLOCK = ~CLOCK;
  cic_ctrl dut (.*);
  cic_core_model core (.clk(CLOCK), .rst(RST), .irq(IRQ_OUT), .fast_request_line(FIQ_OUT), .irq_seen(irq_seen),
    .fiq_seen(fiq_seen));
  // group priority is the field above the binary point
  function pexp(input [7:0] p, input [7:0] r, input [2:0] b);
    pexp = (p >> (b + 1)) < (r >> (b + 1));
  endfunction
  function [31:0] nsv(input [31:0] c);
    nsv = {22'h0, c[10], 2'h0, c[8], c[7], 4'h0, c[1]};
  endfunction
  task chk(input [8*8-1:0] n, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (e !== g) begin
        failures = failures + 1;
        $display("[FAIL] %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d, input n);
    begin
      @(posedge CLOCK);
      WR <= 1;
      ADDR <= a;
      WDATA <= d;
      NS_ACCESS <= n;
      @(posedge CLOCK);
      WR <= 0;
    end
  endtask
  task rd(input [3:0] a, input n, input [31:0] e);
    begin
      @(posedge CLOCK);
      RD <= 1;
      ADDR <= a;
      NS_ACCESS <= n;
      @(posedge CLOCK);
      RD <= 0;
      #1 chk("rdata", e, RDATA);
    end
  endtask
  task lines(input f, input q);
    begin
      repeat (3) @(posedge CLOCK);
      #1 chk("fast", f, fiq_seen);
      chk("norm", q, irq_seen);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  always @(posedge CLOCK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      test_done;
    end
  end
  initial begin
    s = $urandom(80268);
    repeat (12) @(posedge CLOCK);
    RST <= 0;
    PEND_PRIO <= $urandom;
    rd(0, 0, 0);
    for (i = 0; i < 4; i = i + 1) begin
      s = $urandom & 32'hffff_fffb;
      wr(0, s, 0);
      rd(0, 0, s & 32'h7fb);
      rd(1, 0, nsv(s));
      rd(4'h9, 0, 0);
    end
    wr(0, 0, 0);
    wr(1, 32'h261, 1);
    rd(0, 0, 32'h582);
    for (i = 0; i < 3; i = i + 1) begin
      wr(0, (i > 0) << 9, 0);
      s = $urandom & 32'h3ff;
      wr(2, s, i == 2);
      #1 chk("deact", i != 1, DEACT);
      chk("drop", 1, PRIO_DROP);
      chk("id", s, DEACT_ID);
    end
    wr(3, 32'h5, 0);
    #1 chk("deact", 1, DEACT);
    chk("drop", 0, PRIO_DROP);
    chk("id", 32'h5, DEACT_ID);
    @(posedge CLOCK);
    G0_PEND <= 1;
    for (i = 0; i < 2; i = i + 1) begin
      wr(0, 32'h1 | (i << 3), 0);
      lines(i, !i);
    end
    G0_PEND <= 0;
    G1_PEND <= 1;
    wr(0, 32'ha, 0);
    lines(0, 1);
    @(posedge CLOCK);
    G1_PEND <= 0;
    IRQ_BYPASS <= 1;
    FIQ_BYPASS <= 1;
    for (i = 0; i < 2; i = i + 1) begin
      wr(0, i * 32'h1e0, 0);
      lines(!i, !i);
    end
    for (i = 0; i < 8; i = i + 1) begin
      s = $urandom;
      wr(4, {29'h0, s[2:0]}, 0);
      wr(5, {29'h0, s[5:3]}, 0);
      wr(0, {27'h0, s[6], 4'h0}, 0);
      wr(7, {24'h0, s[15:8]}, 0);
      PEND_PRIO <= s[23:16];
      PEND_GRP1 <= s[24];
      rd(4, 0, {29'h0, s[2:0]});
      rd(5, 0, {29'h0, s[5:3]});
      repeat (2) @(posedge CLOCK);
      #1 chk("preempt", pexp(s[23:16], s[15:8], (s[24] & !s[6]) ? s[5:3] : s[2:0]), PREEMPT);
    end
    test_done;
  end
endmodule
